// file: logic/tpfd_cfg_if.sv
// Interface carrying the raw panel configuration registers from the register file to the timing logic.
`timescale 1ns/1ps
`default_nettype none
interface tpfd_cfg_if;
  logic [7:0] fmt;
  logic [7:0] hpos;
  logic cfg_ok;
  modport src (output fmt, output hpos, input cfg_ok);
  modport dst (input fmt, input hpos, output cfg_ok);
endinterface : tpfd_cfg_if
`default_nettype wire

// file: logic/tpfd_mode_dec.sv
// Decoder from format and grayscale controls to data width, frame modulation and dither size.
`timescale 1ns/1ps
`default_nettype none
module tpfd_mode_dec (
  // Controls
  input wire logic [1:0] data_fmt,
  input wire logic [1:0] dither_opt,
  input wire logic alt_gray_select,
  input wire logic frame_mod_sel_hi,
  input wire logic frame_mod_sel_lo,
  input wire logic dither_enable,
  // Decoded modes
  output tpfd_pkg::tpfd_width_t width,
  output tpfd_pkg::tpfd_frame_mod_t frame_mod,
  output tpfd_pkg::tpfd_dither_t dither
);
  always_comb begin
    if (data_fmt[0]) begin
      width = tpfd_pkg::TPFD_W18;
    end else if (data_fmt[1]) begin
      width = tpfd_pkg::TPFD_W12;
    end else begin
      width = tpfd_pkg::TPFD_W9;
    end
  end

  always_comb begin
    frame_mod = tpfd_pkg::TPFD_FM_BAD;
    dither = tpfd_pkg::TPFD_DBAD;
    unique case ({alt_gray_select, frame_mod_sel_hi, frame_mod_sel_lo})
      3'h0: begin
        frame_mod = tpfd_pkg::TPFD_FM16;
        dither = tpfd_pkg::TPFD_DNONE;
      end
      3'h3: begin
        if (dither_enable) begin
          frame_mod = tpfd_pkg::TPFD_FM16;
          if (dither_opt == 2'h0) dither = tpfd_pkg::TPFD_DX4;
          else if (dither_opt == 2'h1) dither = tpfd_pkg::TPFD_DX2;
        end
      end
      3'h6: begin
        frame_mod = tpfd_pkg::TPFD_FM8;
        if (!dither_enable) dither = tpfd_pkg::TPFD_DNONE;
        else if (dither_opt == 2'h0) dither = tpfd_pkg::TPFD_DX8;
        else if (dither_opt == 2'h1) dither = tpfd_pkg::TPFD_DX4;
        else if (dither_opt == 2'h3) dither = tpfd_pkg::TPFD_DX2;
      end
      3'h5: begin
        frame_mod = tpfd_pkg::TPFD_FM4;
        if (!dither_enable) dither = tpfd_pkg::TPFD_DNONE;
        else if (dither_opt == 2'h0) dither = tpfd_pkg::TPFD_DX16;
        else if (dither_opt == 2'h1) dither = tpfd_pkg::TPFD_DX8;
        else if (dither_opt == 2'h3) dither = tpfd_pkg::TPFD_DX4;
      end
      default: begin
        frame_mod = tpfd_pkg::TPFD_FM_BAD;
        dither = tpfd_pkg::TPFD_DBAD;
      end
    endcase
  end
endmodule : tpfd_mode_dec
`default_nettype wire

// file: logic/tpfd_pkg.sv
// Package with register indices, field layouts and mode encodings for the TFT panel format block.
package tpfd_pkg;
  // ---------------------------------------------------------------------------
  // Port addressing
  // ---------------------------------------------------------------------------
  localparam logic [3:0] IDX_DIGIT_MONO = 4'hB;
  localparam logic [3:0] IDX_DIGIT_COLOR = 4'hD;
  localparam logic [3:0] INDEX_DIGIT = 4'h4;
  localparam logic [3:0] DATA_DIGIT = 4'h5;
  localparam logic [7:0] PORT_HI = 8'h03;
  localparam logic [7:0] IDX_DATA_FORMAT = 8'h09;
  localparam logic [7:0] IDX_HSYNC_POS = 8'h0A;
  // ---------------------------------------------------------------------------
  // Field layout of the data format register
  // ---------------------------------------------------------------------------
  localparam logic [7:0] FMT_WRITE_MASK = 8'h7F;
  localparam int FMT_DELAY_LSB = 4;
  localparam int FMT_DITH_LSB = 2;
  localparam logic [7:0] FMT_RESET = 8'h00;
  localparam logic [7:0] HPOS_RESET = 8'h00;
  localparam logic [3:0] DOTS_PER_CHAR = 4'h8;
  // ---------------------------------------------------------------------------
  // Modes
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {TPFD_W9, TPFD_W12, TPFD_W18} tpfd_width_t;
  typedef enum logic [2:0] {TPFD_FM16, TPFD_FM8, TPFD_FM4, TPFD_FM_BAD} tpfd_frame_mod_t;
  typedef enum logic [2:0] {TPFD_DNONE, TPFD_DX2, TPFD_DX4, TPFD_DX8, TPFD_DX16, TPFD_DBAD} tpfd_dither_t;
endpackage : tpfd_pkg

// file: logic/tpfd_top.sv
// TFT panel data format and horizontal sync delay block with its indexed register port.
//
// Behaviour
// - Data format register sits at extension index 9, only while unlock bit is one.
// - Index port digit is B in monochrome mode and D in color mode.
// - Panel horizontal sync delayed 0 to 7 dots from character counter per bits 6:4.
// - Larger delay value moves the panel image further left.
// - Normal gray with both select bits 0 gives 16-frame modulation, no dithering.
// - Normal gray, selects 11, dither on: 16-frame; option 00 x4, 01 x2.
// - Alternate gray, selects 10: 8-frame; dither options 00/01/11 give x8/x4/x2.
// - Alternate gray, selects 01: 4-frame; dither options 00/01/11 give x16/x8/x4.
// - Format 00 is 9-bit, 10 is 12-bit, any odd value is 18-bit.
// - Sync position register sits at extension index A under the same unlock gating.
// - Alternate gray bit one selects alternate grayscale mode for monochrome panels.
// - Output select one drives line clock pin as sync for non-data-enable panels.
`timescale 1ns/1ps
`default_nettype none
module tpfd_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Host I/O port
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_hit,
  // Controls held in other registers
  input wire logic color_mode,
  input wire logic extension_unlock_bit,
  input wire logic alt_gray_select,
  input wire logic frame_mod_sel_hi,
  input wire logic frame_mod_sel_lo,
  input wire logic dither_enable,
  input wire logic line_clock_sel,
  input wire logic stn_line_clock,
  // Video timing
  input wire logic dot_en,
  input wire logic line_start,
  // Panel side
  output logic line_clock_out,
  output tpfd_pkg::tpfd_width_t panel_width,
  output tpfd_pkg::tpfd_frame_mod_t frame_mod,
  output tpfd_pkg::tpfd_dither_t dither_size,
  output logic cfg_unsupported
);
  typedef struct packed {
    logic [7:0] index;
    logic [7:0] fmt;
    logic [7:0] hpos;
    logic [7:0] rdata;
    logic [2:0] dot_cnt;
    logic [7:0] char_cnt;
    logic hs_arm;
    logic [2:0] dly_cnt;
    logic hsync;
    logic line_clk;
  } tpfd_state_t;

  tpfd_state_t s_q;
  tpfd_state_t s_d;

  tpfd_cfg_if cfg ();

  tpfd_pkg::tpfd_width_t width_w;
  tpfd_pkg::tpfd_frame_mod_t fm_w;
  tpfd_pkg::tpfd_dither_t dith_w;

  logic [3:0] idx_digit;
  logic idx_sel;
  logic dat_sel;
  logic ext_fmt;
  logic ext_hpos;
  logic [2:0] delay;

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  assign idx_digit = color_mode ? tpfd_pkg::IDX_DIGIT_COLOR : tpfd_pkg::IDX_DIGIT_MONO;
  assign idx_sel = (io_addr == {tpfd_pkg::PORT_HI, idx_digit, tpfd_pkg::INDEX_DIGIT});
  assign dat_sel = (io_addr == {tpfd_pkg::PORT_HI, idx_digit, tpfd_pkg::DATA_DIGIT});
  assign ext_fmt = dat_sel && extension_unlock_bit && (s_q.index == tpfd_pkg::IDX_DATA_FORMAT);
  assign ext_hpos = dat_sel && extension_unlock_bit && (s_q.index == tpfd_pkg::IDX_HSYNC_POS);
  assign io_hit = idx_sel || ext_fmt || ext_hpos;

  assign cfg.fmt = s_q.fmt;
  assign cfg.hpos = s_q.hpos;
  assign delay = cfg.fmt[tpfd_pkg::FMT_DELAY_LSB +: 3];

  tpfd_mode_dec u_dec (
    .data_fmt(cfg.fmt[1:0]),
    .dither_opt(cfg.fmt[tpfd_pkg::FMT_DITH_LSB +: 2]),
    .alt_gray_select(alt_gray_select),
    .frame_mod_sel_hi(frame_mod_sel_hi),
    .frame_mod_sel_lo(frame_mod_sel_lo),
    .dither_enable(dither_enable),
    .width(width_w),
    .frame_mod(fm_w),
    .dither(dith_w)
  );

  assign cfg.cfg_ok = (fm_w != tpfd_pkg::TPFD_FM_BAD) && (dith_w != tpfd_pkg::TPFD_DBAD);

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (io_wr && idx_sel) begin
      s_d.index = io_wdata;
    end
    if (io_wr && ext_fmt) begin
      s_d.fmt = io_wdata & tpfd_pkg::FMT_WRITE_MASK;
    end
    if (io_wr && ext_hpos) begin
      s_d.hpos = io_wdata;
    end
    if (io_rd && idx_sel) begin
      s_d.rdata = s_q.index;
    end else if (io_rd && ext_fmt) begin
      s_d.rdata = s_q.fmt & tpfd_pkg::FMT_WRITE_MASK;
    end else if (io_rd && ext_hpos) begin
      s_d.rdata = s_q.hpos;
    end
    // Character counter: 8 dots per character, reset at the start of each line.
    s_d.hs_arm = 1'b0;
    if (line_start) begin
      s_d.dot_cnt = '0;
      s_d.char_cnt = '0;
    end else if (dot_en) begin
      s_d.dot_cnt = s_q.dot_cnt + 3'h1;
      if (s_q.dot_cnt == 3'(tpfd_pkg::DOTS_PER_CHAR - 4'h1)) begin
        s_d.char_cnt = s_q.char_cnt + 8'h01;
        if (s_q.char_cnt == cfg.hpos) begin
          s_d.hs_arm = 1'b1;
        end
      end
    end
    // Sync pulse follows the character match by the programmed number of dots.
    if (s_q.hs_arm) begin
      s_d.dly_cnt = delay;
      s_d.hsync = (delay == 3'h0);
    end else if (dot_en && !s_q.hsync && s_q.dly_cnt != 3'h0) begin
      s_d.dly_cnt = s_q.dly_cnt - 3'h1;
      s_d.hsync = (s_q.dly_cnt == 3'h1);
    end else if (dot_en && s_q.hsync) begin
      s_d.hsync = 1'b0;
    end
    s_d.line_clk = line_clock_sel ? s_q.hsync : stn_line_clock;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '{index: 8'h00, fmt: tpfd_pkg::FMT_RESET, hpos: tpfd_pkg::HPOS_RESET, rdata: 8'h00,
               dot_cnt: 3'h0, char_cnt: 8'h00, hs_arm: 1'b0, dly_cnt: 3'h0, hsync: 1'b0,
               line_clk: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign io_rdata = s_q.rdata;
  assign line_clock_out = s_q.line_clk;
  assign panel_width = width_w;
  assign frame_mod = fm_w;
  assign dither_size = dith_w;
  assign cfg_unsupported = !cfg.cfg_ok;
endmodule : tpfd_top
`default_nettype wire

// file: tb/testbench.sv
// Register port and mode decode bench for the TFT panel format block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk, nrst, io_wr, io_rd, io_hit, color_mode, extension_unlock_bit, alt_gray_select;
  logic frame_mod_sel_hi, frame_mod_sel_lo, dither_enable, line_clock_sel, stn_line_clock;
  logic dot_en, line_start, line_clock_out, cfg_unsupported, hit;
  logic [15:0] io_addr, cyc, rise, t0;
  logic [7:0] io_wdata, io_rdata;
  logic [3:0] dg;
  tpfd_pkg::tpfd_width_t panel_width;
  tpfd_pkg::tpfd_frame_mod_t frame_mod;
  tpfd_pkg::tpfd_dither_t dither_size;
  int mismatches, check_count, n;
  logic [11:0] tbl [11] = '{12'h1C0, 12'h702, 12'h741, 12'hC48, 12'hD0B, 12'hD4A, 12'hDC9, 12'hAD0,
    12'hB14, 12'hB53, 12'hBD2};
  assign dg = color_mode ? 4'hD : 4'hB;
  tpfd_top dut (.core_clk(core_clk), .nrst(nrst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_hit(io_hit), .color_mode(color_mode),
    .extension_unlock_bit(extension_unlock_bit), .alt_gray_select(alt_gray_select),
    .frame_mod_sel_hi(frame_mod_sel_hi), .frame_mod_sel_lo(frame_mod_sel_lo), .dither_enable(dither_enable),
    .line_clock_sel(line_clock_sel), .stn_line_clock(stn_line_clock), .dot_en(dot_en),
    .line_start(line_start), .line_clock_out(line_clock_out), .panel_width(panel_width),
    .frame_mod(frame_mod), .dither_size(dither_size), .cfg_unsupported(cfg_unsupported));
  tpfd_panel_model panel (.core_clk(core_clk), .nrst(nrst), .line_clock_out(line_clock_out),
    .cyc_q(cyc), .rise_q(rise));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One strobe cycle; the stn level toggles so the pass-through path stays busy.
  task automatic acc(input logic [15:0] a, input logic w, input logic [7:0] d);
    @(negedge core_clk);
    {io_addr, io_wr, io_rd, io_wdata} = {a, w, !w, d};
    stn_line_clock = ~stn_line_clock;
    #1 hit = io_hit;
    @(negedge core_clk);
    {io_wr, io_rd} = 2'b00;
  endtask : acc
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    acc({8'h03, dg, 4'h4}, 1'b1, idx);
    acc({8'h03, dg, 4'h5}, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    acc({8'h03, dg, 4'h4}, 1'b1, idx);
    acc({8'h03, dg, 4'h5}, 1'b0, 8'h00);
    chk("read data", 16'(io_rdata), 16'(e));
  endtask : rd
  initial begin
    {io_addr, io_wr, io_rd, io_wdata, color_mode, extension_unlock_bit, alt_gray_select} = '0;
    {frame_mod_sel_hi, frame_mod_sel_lo, dither_enable, line_clock_sel, stn_line_clock} = '0;
    {dot_en, line_start, nrst} = '0;
    repeat (3) @(negedge core_clk);
    nrst = 1'b1;
    {color_mode, extension_unlock_bit} = 2'b11;
    rd(8'h09, 8'h00);
    wr(8'h09, 8'hB5);
    rd(8'h09, 8'h35);
    wr(8'h0A, 8'hA5);
    rd(8'h0A, 8'hA5);
    for (int i = 0; i < 4; i++) begin
      wr(8'h09, 8'(i));
      chk("width", 16'(panel_width), (i == 0) ? 16'h0000 : (i == 2) ? 16'h0001 : 16'h0002);
    end
    extension_unlock_bit = 1'b0;
    wr(8'h09, 8'h11);
    chk("locked hit", 16'(hit), 16'h0000);
    extension_unlock_bit = 1'b1;
    rd(8'h09, 8'h03);
    color_mode = 1'b0;
    acc(16'h03D5, 1'b0, 8'h00);
    chk("mono hit", 16'(hit), 16'h0000);
    rd(8'h0A, 8'hA5);
    foreach (tbl[k]) begin
      {alt_gray_select, frame_mod_sel_hi, frame_mod_sel_lo, dither_enable} = tbl[k][11:8];
      wr(8'h09, {4'h0, tbl[k][7:6], 2'h0});
      chk("frame mod", 16'(frame_mod), 16'(tbl[k][5:3]));
      chk("dither", 16'(dither_size), 16'(tbl[k][2:0]));
      chk("unsupported", 16'(cfg_unsupported), 16'h0000);
    end
    wr(8'h09, 8'h08);
    chk("unsupported", 16'(cfg_unsupported), 16'h0001);
    {alt_gray_select, frame_mod_sel_hi, frame_mod_sel_lo} = 3'b100;
    #1 chk("unlisted mode", 16'(cfg_unsupported), 16'h0001);
    // Dots stay frozen between lines so no earlier sync pulse is left pending.
    {line_clock_sel, dot_en} = 2'b10;
    wr(8'h0A, 8'h00);
    for (int d = 0; d < 8; d++) begin
      wr(8'h09, {1'b0, 3'(d), 4'h0});
      @(negedge core_clk);
      {line_start, dot_en} = 2'b11;
      t0 = cyc;
      @(negedge core_clk);
      line_start = 1'b0;
      for (n = 0; n < 200 && rise <= t0; n++) @(negedge core_clk);
      dot_en = 1'b0;
      if (n == 200) begin
        mismatches++;
        close_out();
      end
      chk("sync delay", rise - t0, 16'(tpfd_pkg::DOTS_PER_CHAR) + 16'h0003 + 16'(d));
    end
    close_out();
  end
endmodule : testbench
`default_nettype wire

// file: tb/tpfd_panel_model.sv
// Panel stand-in that timestamps sync rising edges.
`timescale 1ns/1ps
`default_nettype none
module tpfd_panel_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Panel pin
  input wire logic line_clock_out,
  // Observations
  output logic [15:0] cyc_q,
  output logic [15:0] rise_q
);
  logic last_q;
  // The sync input of a non-data-enable panel reacts to each rising edge.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cyc_q <= 16'h0000;
      rise_q <= 16'h0000;
      last_q <= 1'b0;
    end else begin
      cyc_q <= cyc_q + 16'h0001;
      last_q <= line_clock_out;
      if (line_clock_out && !last_q) begin
        rise_q <= cyc_q;
      end
    end
  end
endmodule : tpfd_panel_model
`default_nettype wire

// file: tb/tpfd_top_sva.sv
// Port checker for the TFT panel format block.
`timescale 1ns/1ps
`default_nettype none
module tpfd_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Watched ports
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic io_hit,
  input wire logic color_mode,
  input wire logic extension_unlock_bit,
  input wire logic alt_gray_select,
  input wire logic frame_mod_sel_hi,
  input wire logic frame_mod_sel_lo,
  input wire logic dither_enable,
  input wire logic line_clock_sel,
  input wire logic stn_line_clock,
  input wire logic line_clock_out,
  input wire tpfd_pkg::tpfd_frame_mod_t frame_mod,
  input wire tpfd_pkg::tpfd_dither_t dither_size,
  input wire logic cfg_unsupported
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic [3:0] dg;
  logic [3:0] ng;
  logic acs;
  assign dg = color_mode ? 4'hD : 4'hB;
  assign ng = color_mode ? 4'hB : 4'hD;
  assign acs = io_wr || io_rd;
  sequence stn_pick;
    !line_clock_sel;
  endsequence
  idx_port_hit_a: assert property (acs && io_addr == {8'h03, dg, 4'h4} |-> io_hit)
    else $error("index port missed");
  wrong_digit_a: assert property (acs && io_addr[15:4] == {8'h03, ng} |-> !io_hit)
    else $error("other digit decoded");
  locked_data_a: assert property (io_addr[3:0] == 4'h5 && !extension_unlock_bit |-> !io_hit)
    else $error("data port open while locked");
  normal_gray_a: assert property (!alt_gray_select && !frame_mod_sel_hi && !frame_mod_sel_lo
    |-> frame_mod == tpfd_pkg::TPFD_FM16 && dither_size == tpfd_pkg::TPFD_DNONE && !cfg_unsupported)
    else $error("mode 16 wrong");
  alt_eight_a: assert property (alt_gray_select && frame_mod_sel_hi && !frame_mod_sel_lo && !dither_enable
    |-> frame_mod == tpfd_pkg::TPFD_FM8 && dither_size == tpfd_pkg::TPFD_DNONE) else $error("mode 8 wrong");
  alt_four_a: assert property (alt_gray_select && !frame_mod_sel_hi && frame_mod_sel_lo && !dither_enable
    |-> frame_mod == tpfd_pkg::TPFD_FM4 && dither_size == tpfd_pkg::TPFD_DNONE) else $error("mode 4 wrong");
  unsup_flag_a: assert property ((alt_gray_select ? (frame_mod_sel_hi == frame_mod_sel_lo)
    : (frame_mod_sel_hi != frame_mod_sel_lo)) |-> cfg_unsupported) else $error("unlisted mode accepted");
  stn_pass_a: assert property (stn_pick |=> line_clock_out == $past(stn_line_clock))
    else $error("line clock not passed");
endmodule : tpfd_chk
bind tpfd_top tpfd_chk u_chk (.core_clk, .nrst, .io_addr, .io_wr, .io_rd, .io_hit, .color_mode,
  .extension_unlock_bit, .alt_gray_select, .frame_mod_sel_hi, .frame_mod_sel_lo, .dither_enable,
  .line_clock_sel, .stn_line_clock, .line_clock_out, .frame_mod, .dither_size, .cfg_unsupported);
`default_nettype wire
